// >>> hdl/ptc_cfg.svh
// command codes, field positions and fixed values for the telemetry/id/config bank
// assumes inclusion by the ptc_bank module only
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH
`define PTC_CMD_TEMP_SECOND 8'h8f
`define PTC_CMD_POUT 8'h96
`define PTC_CMD_PIN 8'h97
`define PTC_CMD_SPEC_REV 8'h98
`define PTC_CMD_DEV_ID 8'had
`define PTC_CMD_DEV_REV 8'hae
`define PTC_CMD_RESCALE 8'he7
`define PTC_CMD_RECALL 8'hf2
`define PTC_SPEC_REV_VAL 8'h33
`define PTC_SPEC_P1_MSB 7
`define PTC_SPEC_P1_LSB 4
`define PTC_SPEC_P2_MSB 3
`define PTC_SPEC_P2_LSB 0
`define PTC_RESCALE_VAL 16'h0001
`define PTC_RESCALE_LEN 3'h2
`define PTC_RECALL_LEN 3'h1
`define PTC_RECALL_IDX_MSB 3
`define PTC_RECALL_IDX_LSB 0
`define PTC_WORD_LEN 3'h2
`define PTC_BYTE_LEN 3'h1
`define PTC_BLOCK_LEN 3'h4
`define PTC_CML_BAD_CMD 1
`define PTC_CML_BAD_DATA 0
`define PTC_ID_RSVD_BYTE 8'h00
`endif

// >>> hdl/ptc_pkg.sv
// types shared by the bank and its surroundings
// constants live in ptc_cfg.svh
package ptc_pkg;
  typedef enum logic [0:0] {
    PTC_IDLE = 1'b0,
    PTC_LOAD = 1'b1
  } ptc_recall_st_t;
  typedef logic [15:0] ptc_word_t;
endpackage

// >>> hdl/ptc_bank.sv
// command-level register bank: telemetry words, id/revision blocks, rescale and recall
// assumes a bus framing layer that decodes each transaction into one strobe,
// and telemetry/nvm logic on the same clock
`timescale 1ns/1ps
`include "ptc_cfg.svh"
// How it works
// - 8Fh returns second-pin diode temperature word, or zero when diode sensing is off
// - 96h returns output power of selected page
// - 97h returns input power, page ignored
// - revision byte 33h, two nibble parts
// - ADh block: maker, id high, low, reserved
// - AEh block: firmware, factory, foundry, silicon
// - rescale latches thresholds into operational values
// - F2h low nibble selects stored configuration load
// - flag bad command bit1, bad data bit0
module ptc_bank #(
  parameter int NPAGE = 2,
  parameter int NTHR = 8,
  parameter logic [7:0] MAKER_CODE = 8'h5a,
  parameter logic [15:0] PART_ID = 16'h1234,
  parameter logic [7:0] FW_REV = 8'h01,
  parameter logic [7:0] FACTORY_CFG = 8'h00,
  parameter logic [3:0] FOUNDRY_SITE = 4'h0,
  parameter logic [3:0] SILICON_REV = 4'h0
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // decoded command port
  input wire logic [7:0] cmd_i,
  input wire logic wr_i,
  input wire logic [2:0] wr_len_i,
  input wire logic [31:0] wr_data_i,
  input wire logic rd_i,
  input wire logic [$clog2(NPAGE)-1:0] page_i,
  output logic rd_valid_o,
  output logic [31:0] rd_data_o,
  output logic [2:0] rd_len_o,
  // communication status
  input wire logic clear_faults_i,
  output logic [1:0] cml_flags_o,
  // telemetry
  input wire logic diode_mode_i,
  input wire ptc_pkg::ptc_word_t temp_second_i,
  input wire logic [NPAGE*16-1:0] pout_i,
  input wire ptc_pkg::ptc_word_t pin_i,
  // thresholds and operational values
  input wire logic [NTHR*16-1:0] thr_written_i,
  output logic [NTHR*16-1:0] thr_active_o,
  output logic rescale_o,
  // nonvolatile configuration recall
  input wire logic [15:0] nvm_present_i,
  input wire logic nvm_done_i,
  output logic recall_req_o,
  output logic [3:0] recall_idx_o,
  output logic recall_busy_o
);
  import ptc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic rd_valid_r, rd_valid_nxt;
  logic [31:0] rd_data_r, rd_data_nxt;
  logic [2:0] rd_len_r, rd_len_nxt;
  logic [1:0] cml_r, cml_nxt;
  logic [NTHR*16-1:0] thr_r, thr_nxt;
  logic rescale_r, rescale_nxt;
  ptc_recall_st_t st_r, st_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [15:0] pout_sel;
  logic bad_cmd, bad_data;
  logic [3:0] wr_idx;

  assign wr_idx = wr_data_i[`PTC_RECALL_IDX_MSB:`PTC_RECALL_IDX_LSB];

  // page mux; an out-of-range page reads as zero
  always_comb begin
    pout_sel = 16'h0000;
    for (int p = 0; p < NPAGE; p++) begin
      if (page_i == p[$clog2(NPAGE)-1:0]) begin
        pout_sel = pout_i[p*16 +: 16];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: answer one cycle after the strobe
  always_comb begin
    rd_valid_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    rd_len_nxt = rd_len_r;
    if (rd_i) begin
      rd_valid_nxt = 1'b1;
      rd_data_nxt = 32'h0000_0000;
      rd_len_nxt = `PTC_WORD_LEN;
      case (cmd_i)
        `PTC_CMD_TEMP_SECOND: begin
          // without diode sensing the pin carries no temperature, so report zero
          rd_data_nxt = diode_mode_i ? {16'h0000, temp_second_i} : 32'h0000_0000;
        end
        `PTC_CMD_POUT: begin
          rd_data_nxt = {16'h0000, pout_sel};
        end
        `PTC_CMD_PIN: begin
          rd_data_nxt = {16'h0000, pin_i};
        end
        `PTC_CMD_SPEC_REV: begin
          rd_len_nxt = `PTC_BYTE_LEN;
          rd_data_nxt = {24'h000000, `PTC_SPEC_REV_VAL};
        end
        `PTC_CMD_DEV_ID: begin
          rd_len_nxt = `PTC_BLOCK_LEN;
          rd_data_nxt = {MAKER_CODE, PART_ID, `PTC_ID_RSVD_BYTE};
        end
        `PTC_CMD_DEV_REV: begin
          rd_len_nxt = `PTC_BLOCK_LEN;
          rd_data_nxt = {8'h00, FW_REV, FACTORY_CFG, FOUNDRY_SITE, SILICON_REV};
        end
        default: begin
          rd_len_nxt = 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= 32'h0000_0000;
      rd_len_r <= 3'h0;
    end else begin
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
      rd_len_r <= rd_len_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error classification of the current strobe
  always_comb begin
    bad_cmd = 1'b0;
    bad_data = 1'b0;
    if (rd_i) begin
      case (cmd_i)
        `PTC_CMD_TEMP_SECOND, `PTC_CMD_POUT, `PTC_CMD_PIN,
        `PTC_CMD_SPEC_REV, `PTC_CMD_DEV_ID, `PTC_CMD_DEV_REV: bad_cmd = 1'b0;
        default: bad_cmd = 1'b1;
      endcase
    end else if (wr_i) begin
      case (cmd_i)
        `PTC_CMD_RESCALE: begin
          // the host is expected to send exactly 01h, anything else is refused
          bad_data = (wr_len_i != `PTC_RESCALE_LEN) ||
                     (wr_data_i[15:0] != `PTC_RESCALE_VAL);
        end
        `PTC_CMD_RECALL: begin
          // a recall during a load or of an empty slot leaves settings alone
          bad_data = (wr_len_i != `PTC_RECALL_LEN) || !nvm_present_i[wr_idx] ||
                     (st_r != PTC_IDLE);
        end
        default: bad_cmd = 1'b1;
      endcase
    end
  end

  // set wins over clear so an error in the clearing cycle is kept
  always_comb begin
    cml_nxt = clear_faults_i ? 2'h0 : cml_r;
    if (bad_cmd) begin
      cml_nxt[`PTC_CML_BAD_CMD] = 1'b1;
    end
    if (bad_data) begin
      cml_nxt[`PTC_CML_BAD_DATA] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rescale: written thresholds only take effect here
  always_comb begin
    thr_nxt = thr_r;
    rescale_nxt = 1'b0;
    if (wr_i && (cmd_i == `PTC_CMD_RESCALE) && !bad_data) begin
      thr_nxt = thr_written_i;
      rescale_nxt = 1'b1;
    end
  end

  // recall: request held until the nvm side reports the load complete
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    case (st_r)
      PTC_IDLE: begin
        if (wr_i && (cmd_i == `PTC_CMD_RECALL) && !bad_data) begin
          idx_nxt = wr_idx;
          st_nxt = PTC_LOAD;
        end
      end
      PTC_LOAD: begin
        if (nvm_done_i) begin
          st_nxt = PTC_IDLE;
        end
      end
      default: begin
        st_nxt = PTC_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cml_r <= 2'h0;
    end else begin
      cml_r <= cml_nxt;
    end
  end

  // operational thresholds; they read as zero until the first rescale
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      thr_r <= '0;
      rescale_r <= 1'b0;
    end else begin
      thr_r <= thr_nxt;
      rescale_r <= rescale_nxt;
    end
  end

  // recall state and the index it holds while the load runs
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_r <= PTC_IDLE;
      idx_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign rd_valid_o = rd_valid_r;
  assign rd_data_o = rd_data_r;
  assign rd_len_o = rd_len_r;
  assign cml_flags_o = cml_r;
  assign thr_active_o = thr_r;
  assign rescale_o = rescale_r;
  assign recall_req_o = (st_r == PTC_LOAD);
  assign recall_busy_o = (st_r == PTC_LOAD);
  assign recall_idx_o = idx_r;
endmodule

// >>> tb/ptc_bank_checker.sv
// checker for the command bank: read answers, flags, rescale, recall
// assumes it is bound into ptc_bank
`timescale 1ns/1ps
module ptc_bank_checker #(parameter int NTHR = 8) (
  // clock, reset, command port
  input wire logic sys_clk_i, rst_i, rd_i, wr_i, nvm_done_i,
  input wire logic [7:0] cmd_i,
  input wire logic [2:0] wr_len_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [15:0] nvm_present_i,
  input wire logic [NTHR*16-1:0] thr_written_i,
  // outputs watched
  input wire logic rd_valid_o, rescale_o, recall_req_o, recall_busy_o,
  input wire logic [2:0] rd_len_o,
  input wire logic [31:0] rd_data_o,
  input wire logic [1:0] cml_flags_o,
  input wire logic [3:0] recall_idx_o,
  input wire logic [NTHR*16-1:0] thr_active_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  rd_answer_a: assert property (rd_i |=> rd_valid_o)
    else $error("no answer");
  rd_quiet_a: assert property (!rd_i |=> !rd_valid_o)
    else $error("stray answer");
  spec_rev_a: assert property (rd_i && cmd_i == 8'h98 |=> rd_data_o == 32'h33)
    else $error("bad revision");
  bad_cmd_a: assert property (rd_i && cmd_i == 8'h00 |=> cml_flags_o[1])
    else $error("no bad command flag");
  rescale_take_a: assert property (wr_i && !rd_i && cmd_i == 8'he7 && wr_len_i == 3'h2
    && wr_data_i[15:0] == 16'h1 |=> rescale_o && thr_active_o == $past(thr_written_i))
    else $error("rescale not taken");
  rescale_src_a: assert property (rescale_o |-> $past(wr_i) && $past(cmd_i) == 8'he7)
    else $error("stray rescale");
  recall_take_a: assert property (wr_i && !rd_i && cmd_i == 8'hf2 && wr_len_i == 3'h1
    && !recall_busy_o && nvm_present_i[wr_data_i[3:0]] |=> recall_req_o
    && recall_idx_o == $past(wr_data_i[3:0]))
    else $error("recall not taken");
  recall_end_a: assert property (nvm_done_i && recall_req_o |=> !recall_req_o)
    else $error("recall stuck");
  recall_empty_a: assert property (wr_i && !rd_i && cmd_i == 8'hf2 && !recall_busy_o
    && !nvm_present_i[wr_data_i[3:0]] |=> !recall_req_o && cml_flags_o[0])
    else $error("empty slot recalled");
endmodule
bind ptc_bank ptc_bank_checker #(.NTHR(NTHR)) u_chk (.sys_clk_i, .rst_i, .rd_i, .wr_i,
  .nvm_done_i, .cmd_i, .wr_len_i, .wr_data_i, .nvm_present_i, .thr_written_i, .rd_valid_o,
  .rescale_o, .recall_req_o, .recall_busy_o, .rd_len_o, .rd_data_o, .cml_flags_o,
  .recall_idx_o, .thr_active_o);

// >>> tb/ptc_nvm_model.sv
// stub of the nonvolatile store: finishes a load LAT cycles after the request
// assumes the bank's recall handshake on the same clock
`timescale 1ns/1ps
module ptc_nvm_model #(parameter int LAT = 6) (
  input wire logic sys_clk_i, rst_i, req_i,
  output logic done_o = 1'b0
);
  int cnt = 0;
  // cnt runs on past LAT, so one request gets exactly one done
  always @(posedge sys_clk_i) begin
    cnt <= (rst_i || !req_i) ? 0 : cnt + 1;
    done_o <= !rst_i && req_i && cnt == LAT - 1;
  end
endmodule

// >>> tb/test_ptc_bank.sv
// self-checking bench for the command bank with an nvm stub
// assumes the bank's default page and threshold counts
`timescale 1ns/1ps
module test_ptc_bank;
  import ptc_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, rd_i = 0, wr_i = 0, page_i = 0, clear_faults_i = 0;
  logic diode_mode_i = 1, rd_valid_o, rescale_o, recall_req_o, recall_busy_o, nvm_done_i;
  logic [7:0] cmd_i = 0;
  logic [2:0] wr_len_i = 0, rd_len_o;
  logic [31:0] wr_data_i = 0, rd_data_o, pout_i = 32'h0456_0789;
  ptc_word_t temp_second_i = 16'hff38, pin_i = 16'h0123;
  logic [127:0] thr_written_i = {8{16'ha5c3}}, thr_active_o;
  logic [15:0] nvm_present_i = 16'h0009;
  logic [1:0] cml_flags_o;
  logic [3:0] recall_idx_o;
  // command, answer, length; maker 5ah and part 1234h are the arbitrary ids
  logic [42:0] rows [7] = '{{8'h8f, 32'hff38, 3'h2}, {8'h96, 32'h789, 3'h2},
    {8'h97, 32'h123, 3'h2}, {8'h98, 32'h33, 3'h1}, {8'had, 32'h5a12_3400, 3'h4},
    {8'hae, 32'h0001_0000, 3'h4}, {8'h00, 32'h0, 3'h0}};
  int bad_count = 0, n_checks = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  ptc_bank u_dut (.*);
  ptc_nvm_model u_nvm (.sys_clk_i, .rst_i, .req_i(recall_req_o), .done_o(nvm_done_i));
  task automatic chk(input logic [127:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic r, w, input logic [7:0] c, input logic [2:0] l,
    input logic [31:0] d);
    @(posedge sys_clk_i);
    #1 {rd_i, wr_i, cmd_i, wr_len_i, wr_data_i} = {r, w, c, l, d};
    @(posedge sys_clk_i);
    #1 {rd_i, wr_i} = 2'b00;
  endtask
  task automatic rdc(input logic [42:0] row);
    op(1, 0, row[42:35], 0, 0);
    chk({rd_valid_o, rd_len_o, rd_data_o}, {1'b1, row[2:0], row[34:3]});
  endtask
  task automatic clr;
    @(posedge sys_clk_i);
    #1 clear_faults_i = 1;
    @(posedge sys_clk_i);
    #1 clear_faults_i = 0;
  endtask
  task automatic summarize;
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    #1 rst_i = 0;
    chk({rd_len_o, cml_flags_o, recall_req_o, thr_active_o[31:0]}, 0);
    foreach (rows[i]) rdc(rows[i]);
    chk(cml_flags_o, 2'b10);
    clr();
    diode_mode_i = 0;
    page_i = 1;
    rdc({8'h8f, 32'h0, 3'h2});
    rdc({8'h96, 32'h456, 3'h2});
    rdc({8'h97, 32'h123, 3'h2});
    op(0, 1, 8'h97, 2, 0);
    chk(cml_flags_o, 2'b10);
    clr();
    op(0, 1, 8'he7, 1, 1);
    chk({rescale_o, cml_flags_o, thr_active_o[124:0]}, {3'b001, 125'h0});
    clr();
    op(0, 1, 8'he7, 2, 1);
    chk({rescale_o, thr_active_o[126:0]}, {1'b1, thr_written_i[126:0]});
    op(0, 1, 8'hf2, 1, 32'hf3);
    chk({recall_req_o, recall_idx_o}, 5'h13);
    op(0, 1, 8'hf2, 1, 0);
    chk({recall_idx_o, cml_flags_o}, 6'h0d);
    for (int i = 0; i < 20 && recall_busy_o; i++) @(posedge sys_clk_i);
    #1 chk(recall_req_o, 0);
    clr();
    op(0, 1, 8'hf2, 1, 2);
    chk({recall_req_o, cml_flags_o}, 3'b001);
    rst_i = 1;
    repeat (2) @(posedge sys_clk_i);
    #1 rst_i = 0;
    chk({rd_len_o, cml_flags_o, recall_req_o, thr_active_o[31:0]}, 0);
    summarize();
  end
endmodule
